// ==== core/ars_ramp_selector.sv ====
`include "ars_params.svh"
// Operation
// - four ramp pairs, chosen by inputs, motor, speed
// - accel value is time zero to maximum
// - decel value is time maximum to zero
// - nothing selected uses pair one
// - two select inputs decode to pairs 1..4
// - motor one pairs 1-2, motor two 3-4
// - select2 with motor switching refused, error
// - no motor two with permanent-magnet motor
// - nonzero dwell end speed disables switching
// - auto: pair 1 at/above threshold, else 4
// - digital selection overrides speed switching
// - threshold 0..100.0 %, zero disables auto
// - emergency stop ramp on fault or input
// - emergency stop request latched on NO closure or NC opening
// - restart blocked until stopped, released, run cycled
// - resolution two or one decimal places
// - unit 5/6 means acceleration, except V/f
// - separate motor two accel/decel times
// - inspection run uses inspection decel ramp
module ars_ramp_selector #(
  parameter int CYC_FINE   = `ARS_CLK_HZ / `ARS_MS_PER_S * `ARS_T_FINE_MS,
  parameter int CYC_COARSE = `ARS_CLK_HZ / `ARS_MS_PER_S * `ARS_T_COARSE_MS
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        dig_sel1,
  input  wire logic        dig_sel2,
  input  wire logic        dig_motor2,
  input  wire logic        dig_estop,
  input  wire logic        fault_estop,
  input  wire logic        run_cmd,
  input  wire logic        inspection,
  input  wire logic [15:0] speed_target,
  output logic      [15:0] speed_ref,
  output logic      [1:0]  active_pair,
  output logic             motor2_active,
  output logic             estop_active,
  output logic             restart_block,
  output logic             input_conflict_error
);
  // ****************************************************************
  // registers
  // ****************************************************************
  ars_pkg::ars_ramp_t ramp_r [0:7];
  ars_pkg::ars_ramp_t estop_time_r, m2acc_r, m2dec_r, insp_r, thr_r, dwell_r;
  logic               res_r;
  logic [10:0]        cfg_r;
  logic               wr_pend_r;
  logic [7:0]         wr_addr_r;
  logic [31:0]        rd_mux;
  logic [15:0]        wv;
  logic               cfg_bad;

  function automatic ars_pkg::ars_ramp_t sat(input logic [31:0] v,
                                             input logic [15:0] mx);
    sat = (v > {16'h0000, mx}) ? mx : v[15:0];
  endfunction

  assign wv = hwdata[15:0];
  assign cfg_bad = hwdata[`ARS_CFG_SEL2] & hwdata[`ARS_CFG_MSEL];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_r <= hsel & hready & htrans[1] & hwrite;
      if (hsel & hready & htrans[1]) begin
        wr_addr_r <= haddr[7:0];
        hrdata    <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) ramp_r[i] <= `ARS_RST_RAMP;
      estop_time_r <= `ARS_RST_ESTOP;
      m2acc_r      <= `ARS_RST_M2;
      m2dec_r      <= `ARS_RST_M2;
      insp_r       <= `ARS_RST_INSP;
      thr_r        <= `ARS_RST_THR;
      dwell_r      <= 16'h0000;
      res_r        <= 1'b0;
      cfg_r        <= 11'h000;
      input_conflict_error <= 1'b0;
    end else if (wr_pend_r) begin
      if (wr_addr_r < `ARS_OFS_ESTOP && wr_addr_r[1:0] == 2'b00)
        ramp_r[wr_addr_r[4:2]] <= sat(hwdata, `ARS_MAX_RAMP);
      unique case (wr_addr_r)
        `ARS_OFS_ESTOP: estop_time_r <= sat(hwdata, `ARS_MAX_RAMP);
        `ARS_OFS_RES:   res_r        <= hwdata[0];
        `ARS_OFS_THR:   thr_r        <= sat(hwdata, `ARS_MAX_THR);
        `ARS_OFS_M2ACC: m2acc_r      <= sat(hwdata, `ARS_MAX_RAMP);
        `ARS_OFS_M2DEC: m2dec_r      <= sat(hwdata, `ARS_MAX_RAMP);
        `ARS_OFS_INSP:  insp_r       <= sat(hwdata, `ARS_MAX_INSP);
        `ARS_OFS_DWELL: dwell_r      <= wv;
        `ARS_OFS_CFG: begin
          input_conflict_error <= cfg_bad;
          if (!cfg_bad) cfg_r <= hwdata[10:0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (haddr[7:0] < `ARS_OFS_ESTOP && haddr[1:0] == 2'b00)
      rd_mux[15:0] = ramp_r[haddr[4:2]];
    else
      unique case (haddr[7:0])
        `ARS_OFS_ESTOP: rd_mux[15:0] = estop_time_r;
        `ARS_OFS_RES:   rd_mux[0]    = res_r;
        `ARS_OFS_THR:   rd_mux[15:0] = thr_r;
        `ARS_OFS_M2ACC: rd_mux[15:0] = m2acc_r;
        `ARS_OFS_M2DEC: rd_mux[15:0] = m2dec_r;
        `ARS_OFS_INSP:  rd_mux[15:0] = insp_r;
        `ARS_OFS_CFG:   rd_mux[10:0] = cfg_r;
        `ARS_OFS_DWELL: rd_mux[15:0] = dwell_r;
        `ARS_OFS_STAT:
          rd_mux[6:0] = {input_conflict_error, restart_block, estop_active,
                         motor2_active, 1'b0, active_pair};
        `ARS_OFS_SPEED: rd_mux[15:0] = speed_ref;
        default: ;
      endcase
  end

  // ****************************************************************
  // ramp pair selection
  // ****************************************************************
  logic [1:0]  pair_nxt;
  logic        m2_sel, m2_alt, es_trig;
  logic [15:0] acc_nxt, dec_nxt;

  always_comb begin
    m2_sel = cfg_r[`ARS_CFG_MSEL] & dig_motor2 & ~cfg_r[`ARS_CFG_PM];
    m2_alt = 1'b0;
    if (dwell_r != 16'h0000) begin
      pair_nxt = 2'd0;
    end else if (cfg_r[`ARS_CFG_MSEL]) begin
      pair_nxt = {m2_sel, cfg_r[`ARS_CFG_SEL1] & dig_sel1};
      m2_alt   = m2_sel & ~cfg_r[`ARS_CFG_SEL1];
    end else if ((cfg_r[`ARS_CFG_SEL1] & dig_sel1) |
                 (cfg_r[`ARS_CFG_SEL2] & dig_sel2)) begin
      pair_nxt = {cfg_r[`ARS_CFG_SEL2] & dig_sel2,
                  cfg_r[`ARS_CFG_SEL1] & dig_sel1};
    end else if (thr_r != 16'h0000) begin
      pair_nxt = (speed_ref >= thr_r) ? 2'd0 : 2'd3;
    end else begin
      pair_nxt = 2'd0;
    end
    acc_nxt = m2_alt ? m2acc_r : ramp_r[{pair_nxt, 1'b0}];
    dec_nxt = m2_alt ? m2dec_r : ramp_r[{pair_nxt, 1'b1}];
    if (estop_active)
      dec_nxt = estop_time_r;
    else if (inspection)
      dec_nxt = insp_r;
    es_trig = fault_estop | (cfg_r[`ARS_CFG_ES_NO] & dig_estop) |
              (cfg_r[`ARS_CFG_ES_NC] & ~dig_estop);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_pair   <= 2'd0;
      motor2_active <= 1'b0;
    end else if (ce) begin
      active_pair   <= pair_nxt;
      motor2_active <= m2_sel;
    end
  end

  // ****************************************************************
  // emergency stop latch and restart interlock
  // ****************************************************************
  ars_pkg::ars_es_t es_r;
  logic             run_off_r;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      es_r          <= ars_pkg::ARS_ES_IDLE;
      run_off_r     <= 1'b0;
      estop_active  <= 1'b0;
      restart_block <= 1'b0;
    end else if (ce) begin
      unique case (es_r)
        ars_pkg::ARS_ES_IDLE:
          if (es_trig) begin
            es_r          <= ars_pkg::ARS_ES_DECEL;
            run_off_r     <= 1'b0;
            estop_active  <= 1'b1;
            restart_block <= 1'b1;
          end
        ars_pkg::ARS_ES_DECEL: begin
          if (!run_cmd) run_off_r <= 1'b1;
          if (speed_ref == 16'h0000) begin
            es_r         <= ars_pkg::ARS_ES_HOLD;
            estop_active <= 1'b0;
          end
        end
        ars_pkg::ARS_ES_HOLD: begin
          if (!run_cmd) run_off_r <= 1'b1;
          if (!es_trig && run_off_r && run_cmd) begin
            es_r          <= ars_pkg::ARS_ES_IDLE;
            restart_block <= 1'b0;
          end
        end
        default: begin
          es_r          <= ars_pkg::ARS_ES_IDLE;
          estop_active  <= 1'b0;
          restart_block <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // linear ramp generator
  // ****************************************************************
  logic [39:0] acc_r, num, den, sum;
  logic [15:0] tgt, ramp_v;
  logic        up, accel_mode;

  always_comb begin
    tgt = (run_cmd && !restart_block) ?
          ((speed_target > `ARS_SPD_FULL) ? `ARS_SPD_FULL : speed_target) : 16'h0000;
    up  = tgt > speed_ref;
    ramp_v = up ? acc_nxt : dec_nxt;
    accel_mode = (cfg_r[`ARS_CFG_DU_HI:`ARS_CFG_DU_LO] >= `ARS_DU_METRIC) &
                 ~cfg_r[`ARS_CFG_VF];
    if (accel_mode) begin
      num = 40'(ramp_v) * 40'(`ARS_SPD_FULL) * (res_r ? 40'd10 : 40'd1);
      den = 40'(`ARS_CLK_HZ) * 40'(`ARS_VMAX_CMS);
    end else begin
      num = 40'(`ARS_SPD_FULL);
      den = 40'(ramp_v) * (res_r ? 40'(CYC_COARSE) : 40'(CYC_FINE));
    end
    sum = acc_r + num;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r     <= 40'h0;
      speed_ref <= 16'h0000;
    end else if (ce) begin
      if (tgt == speed_ref) begin
        acc_r <= 40'h0;
      end else if (ramp_v == 16'h0000) begin
        speed_ref <= tgt;
        acc_r     <= 40'h0;
      end else if (sum >= den) begin
        // one step a cycle at most: faster rates are capped
        acc_r     <= sum - den;
        speed_ref <= up ? speed_ref + 16'h0001 : speed_ref - 16'h0001;
      end else begin
        acc_r <= sum;
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_no_cfg_pair: assert property (
    ce && dwell_r == 16'h0 && cfg_r[2:0] == 3'h0 && thr_r == 16'h0
      |=> active_pair == 2'd0)
    else $error("pair not one without selection");
  a_dig_decode: assert property (
    ce && dwell_r == 16'h0 && !cfg_r[`ARS_CFG_MSEL] && cfg_r[1:0] == 2'b11
      && (dig_sel1 || dig_sel2) |=> active_pair == $past({dig_sel2, dig_sel1}))
    else $error("select inputs decoded wrongly");
  a_motor_pair: assert property (
    ce && dwell_r == 16'h0 && cfg_r[`ARS_CFG_MSEL] |=> active_pair[1] == motor2_active)
    else $error("motor two not on pairs 3 and 4");
  a_no_conflict: assert property (
    !(cfg_r[`ARS_CFG_SEL2] && cfg_r[`ARS_CFG_MSEL]))
    else $error("conflicting input setup accepted");
  a_pm_motor: assert property (
    ce && cfg_r[`ARS_CFG_PM] |=> !motor2_active)
    else $error("motor two with pm motor");
  a_dwell_hold: assert property (
    ce && dwell_r != 16'h0 |=> active_pair == 2'd0)
    else $error("switching while dwell end speed set");
  a_auto_low: assert property (
    ce && dwell_r == 16'h0 && cfg_r[2:0] == 3'h0 && thr_r != 16'h0
      && speed_ref < thr_r |=> active_pair == 2'd3)
    else $error("pair four not used below threshold");
  a_estop_latch: assert property (
    ce && !restart_block && es_trig ##1 ce && !es_trig |-> estop_active)
    else $error("estop request not latched");
  a_estop_hold: assert property (
    restart_block && !run_off_r |=> restart_block)
    else $error("restart allowed without run cycle");
  a_step_size: assert property (
    ce && ramp_v != 16'h0 |=> (speed_ref - $past(speed_ref) <= 16'h1)
      || ($past(speed_ref) - speed_ref <= 16'h1))
    else $error("ramp moved more than one step");
  a_estop_trig: assert property (
    ce && !restart_block && (fault_estop || (cfg_r[`ARS_CFG_ES_NO] && dig_estop)
      || (cfg_r[`ARS_CFG_ES_NC] && !dig_estop)) |=> estop_active)
    else $error("estop trigger not taken");
  a_estop_fall: assert property (
    ce && estop_active |=> speed_ref <= $past(speed_ref))
    else $error("speed rose during estop");
  a_block_start: assert property (
    ce && restart_block && speed_ref == 16'h0 |=> speed_ref == 16'h0)
    else $error("restart while blocked");
  a_zero_jump: assert property (
    ce && ramp_v == 16'h0 |=> speed_ref == $past(tgt))
    else $error("zero ramp did not jump to target");
  a_thr_range: assert property (
    thr_r <= `ARS_MAX_THR)
    else $error("threshold above full scale");
  a_ramp_range: assert property (
    ramp_r[0] <= `ARS_MAX_RAMP)
    else $error("ramp above its ceiling");
  a_insp_range: assert property (
    insp_r <= `ARS_MAX_INSP)
    else $error("inspection ramp above its ceiling");
endmodule

// ==== core/ars_params.svh ====
`ifndef ARS_PARAMS_SVH
`define ARS_PARAMS_SVH
// ****************************************************************
// clock and timing
// ****************************************************************
`define ARS_CLK_HZ      10000000
`define ARS_T_FINE_MS   10
`define ARS_T_COARSE_MS 100
`define ARS_MS_PER_S    1000
// ****************************************************************
// register byte offsets
// ****************************************************************
`define ARS_OFS_RAMP0   8'h00
`define ARS_OFS_ESTOP   8'h20
`define ARS_OFS_RES     8'h24
`define ARS_OFS_THR     8'h28
`define ARS_OFS_M2ACC   8'h2c
`define ARS_OFS_M2DEC   8'h30
`define ARS_OFS_INSP    8'h34
`define ARS_OFS_CFG     8'h38
`define ARS_OFS_DWELL   8'h3c
`define ARS_OFS_STAT    8'h40
`define ARS_OFS_SPEED   8'h44
// ****************************************************************
// reset values and ranges (0.01 s, 0.1 %)
// ****************************************************************
`define ARS_RST_RAMP    16'h0096
`define ARS_RST_ESTOP   16'h0096
`define ARS_RST_M2      16'h0064
`define ARS_RST_INSP    16'h0000
`define ARS_RST_THR     16'h0000
`define ARS_MAX_RAMP    16'hea60
`define ARS_MAX_INSP    16'h00c8
`define ARS_MAX_THR     16'h03e8
`define ARS_SPD_FULL    16'h03e8
`define ARS_VMAX_CMS    16'h00c8
// ****************************************************************
// configuration fields
// ****************************************************************
`define ARS_CFG_SEL1    0
`define ARS_CFG_SEL2    1
`define ARS_CFG_MSEL    2
`define ARS_CFG_ES_NO   3
`define ARS_CFG_ES_NC   4
`define ARS_CFG_PM      5
`define ARS_CFG_VF      6
`define ARS_CFG_DU_LO   8
`define ARS_CFG_DU_HI   10
`define ARS_DU_METRIC   3'h5
`endif

// ==== core/ars_pkg.sv ====
package ars_pkg;
  typedef logic [15:0] ars_ramp_t;
  typedef enum logic [1:0] {
    ARS_ES_IDLE  = 2'b00,
    ARS_ES_DECEL = 2'b01,
    ARS_ES_HOLD  = 2'b10
  } ars_es_t;
endpackage

// ==== verification/ars_term_model.sv ====
// ****************************************************************
// terminal side: registers the operator's terminal levels
// ****************************************************************
module ars_term_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] sel_req,
  input  wire logic       m2_req,
  input  wire logic       run_req,
  input  wire logic       estop_req,
  output logic            dig_sel1,
  output logic            dig_sel2,
  output logic            dig_motor2,
  output logic            run_cmd,
  output logic            dig_estop
);
  timeunit 1ns;
  timeprecision 1ns;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {dig_sel2, dig_sel1} <= 2'h0;
      dig_motor2           <= 1'b0;
      run_cmd              <= 1'b0;
      dig_estop            <= 1'b0;
    end else begin
      {dig_sel2, dig_sel1} <= sel_req;
      dig_motor2           <= m2_req;
      run_cmd              <= run_req;
      dig_estop            <= estop_req;
    end
  end
endmodule

// ==== verification/tb.sv ====
`include "ars_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        sys_clk, rst_n, hwrite, rd_phase, fault_estop, inspection;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans, sel_req, active_pair;
  logic [15:0] speed_target, speed_ref;
  logic        hreadyout, hresp, m2_req, run_req, estop_req;
  logic        dig_sel1, dig_sel2, dig_motor2, run_cmd, dig_estop;
  logic        motor2_active, estop_active, restart_block, conflict;
  logic [31:0] exp_q[$];
  localparam int TB_FINE = 8;
  int          failures, n_tests, cyc, cnt;
  logic [15:0] rv;
  // ****************************************************************
  // clock, design and terminal model
  // ****************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  ars_ramp_selector #(.CYC_FINE(TB_FINE), .CYC_COARSE(TB_FINE * 10)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dig_sel1(dig_sel1),
    .dig_sel2(dig_sel2), .dig_motor2(dig_motor2), .dig_estop(dig_estop),
    .fault_estop(fault_estop), .run_cmd(run_cmd), .inspection(inspection),
    .speed_target(speed_target), .speed_ref(speed_ref), .active_pair(active_pair),
    .motor2_active(motor2_active), .estop_active(estop_active),
    .restart_block(restart_block), .input_conflict_error(conflict));
  ars_term_model TERM (
    .sys_clk(sys_clk), .rst_n(rst_n), .sel_req(sel_req), .m2_req(m2_req),
    .run_req(run_req), .estop_req(estop_req), .dig_sel1(dig_sel1), .dig_sel2(dig_sel2),
    .dig_motor2(dig_motor2), .run_cmd(run_cmd), .dig_estop(dig_estop));
  // ****************************************************************
  // bus master and checking
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: read %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge sys_clk);
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans   <= 2'h0;
    hwdata   <= d;
    rd_phase <= ~w;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    ahb(a, 1'b0, 32'h0);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
      check({31'h0, hresp}, 32'h0);
      if (exp_q.size() == 0) check(hrdata, 32'hffffffff);
      else check(hrdata, exp_q.pop_front());
    end
  end
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  initial begin
    {rst_n, hwrite, rd_phase, fault_estop, inspection, m2_req, estop_req} = 7'h0;
    {haddr, hwdata, htrans, sel_req, speed_target, failures, n_tests, cyc} = '0;
    run_req = 1'b1;
    wait_cyc(16);
    rst_n <= 1'b1;
    void'($urandom(82133));
    // reset values, unmapped read
    for (int i = 0; i < 19; i++) begin
      rd(8'(i * 4), (i < 9) ? 32'h96 : (i == 11 || i == 12) ? 32'h64 : 32'h0);
    end
    // saturation and random write-back
    ahb(`ARS_OFS_THR, 1'b1, 32'hffff);
    rd(`ARS_OFS_THR, 32'h3e8);
    ahb(`ARS_OFS_INSP, 1'b1, 32'hffff);
    rd(`ARS_OFS_INSP, 32'hc8);
    rv = 16'($urandom % 60001);
    ahb(8'h0c, 1'b1, {16'h0, rv});
    rd(8'h0c, {16'h0, rv});
    ahb(`ARS_OFS_RES, 1'b1, 32'h1);
    rd(`ARS_OFS_RES, 32'h1);
    ahb(`ARS_OFS_THR, 1'b1, 32'h0);
    // conflicting input assignment refused
    ahb(`ARS_OFS_CFG, 1'b1, 32'h6);
    rd(`ARS_OFS_CFG, 32'h0);
    rd(`ARS_OFS_STAT, 32'h40);
    check({31'h0, conflict}, 32'h1);
    ahb(`ARS_OFS_CFG, 1'b1, 32'h3);
    for (int i = 0; i < 4; i++) begin
      sel_req <= 2'(i);
      wait_cyc(2);
      rd(`ARS_OFS_STAT, 32'(i));
      check({30'h0, active_pair}, 32'(i));
    end
    ahb(`ARS_OFS_CFG, 1'b1, 32'h0);
    wait_cyc(2);
    rd(`ARS_OFS_STAT, 32'h0);
    // motor select
    ahb(`ARS_OFS_CFG, 1'b1, 32'h5);
    for (int i = 0; i < 4; i++) begin
      {m2_req, sel_req} <= {i[1], 1'b0, i[0]};
      wait_cyc(2);
      rd(`ARS_OFS_STAT, {28'h0, i[1], 1'b0, i[1], i[0]});
      check({31'h0, motor2_active}, {31'h0, i[1]});
    end
    ahb(`ARS_OFS_CFG, 1'b1, 32'h25);
    {m2_req, sel_req} <= 3'b100;
    wait_cyc(2);
    rd(`ARS_OFS_STAT, 32'h0);
    // dwell end speed disables switching
    m2_req <= 1'b0;
    sel_req <= 2'h3;
    ahb(`ARS_OFS_CFG, 1'b1, 32'h3);
    ahb(`ARS_OFS_DWELL, 1'b1, 32'h5);
    rd(`ARS_OFS_STAT, 32'h0);
    ahb(`ARS_OFS_DWELL, 1'b1, 32'h0);
    rd(`ARS_OFS_STAT, 32'h3);
    // speed-level switching and its override
    sel_req <= 2'h0;
    ahb(`ARS_OFS_CFG, 1'b1, 32'h0);
    ahb(`ARS_OFS_RAMP0, 1'b1, 32'h0);
    ahb(8'h18, 1'b1, 32'h0);
    ahb(`ARS_OFS_THR, 1'b1, 32'd500);
    rd(`ARS_OFS_STAT, 32'h3);
    speed_target <= 16'd1000;
    wait_cyc(3);
    rd(`ARS_OFS_SPEED, 32'd1000);
    check({16'h0, speed_ref}, 32'd1000);
    rd(`ARS_OFS_STAT, 32'h0);
    ahb(`ARS_OFS_CFG, 1'b1, 32'h3);
    sel_req <= 2'h2;
    wait_cyc(2);
    rd(`ARS_OFS_STAT, 32'h2);
    sel_req <= 2'h0;
    ahb(`ARS_OFS_THR, 1'b1, 32'h0);
    // emergency stop on a momentary closure
    ahb(`ARS_OFS_RES, 1'b1, 32'h0);
    ahb(`ARS_OFS_CFG, 1'b1, 32'h8);
    estop_req <= 1'b1;
    @(posedge sys_clk);
    estop_req <= 1'b0;
    wait_cyc(300);
    rd(`ARS_OFS_STAT, 32'h30);
    check({30'h0, restart_block, estop_active}, 32'h3);
    for (int i = 0; i < 2000 && estop_active !== 1'b0; i++) @(posedge sys_clk);
    rd(`ARS_OFS_SPEED, 32'h0);
    rd(`ARS_OFS_STAT, 32'h20);
    run_req <= 1'b0;
    wait_cyc(3);
    rd(`ARS_OFS_STAT, 32'h20);
    run_req <= 1'b1;
    wait_cyc(3);
    rd(`ARS_OFS_STAT, 32'h0);
    check({30'h0, restart_block, estop_active}, 32'h0);
    // inspection run: full-scale stop on the inspection ramp
    inspection   <= 1'b1;
    speed_target <= 16'h0000;
    cnt = 0;
    do begin
      @(posedge sys_clk);
      cnt++;
    end while (speed_ref !== 16'h0000 && cnt < 4000);
    check(32'(cnt / 10), 32'(`ARS_MAX_INSP * TB_FINE / 10));
    wait_cyc(2);
    finish_test();
  end
endmodule
